/* rtl/lpm_defines.svh */
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH

// Width of the sleep-level request code driven by the CPU control bits.
`define SLP_CODE_W 3

// Request codes for the six operating modes.
`define SLP_CODE_RUN   3'h0
`define SLP_CODE_ZERO  3'h1
`define SLP_CODE_ONE   3'h2
`define SLP_CODE_TWO   3'h3
`define SLP_CODE_THREE 3'h4
`define SLP_CODE_FOUR  3'h5

// The crystal driver stays on the pad after reset, as the select bit resets set.
`define CRYSTAL_OUTPUT_PAD_DRV_RST 1'h1

// Test-mode pin decode state after reset: pins are plain port pins.
`define JTAG_SEL_RST 1'h0

`endif

/* rtl/lpm_pkg.sv */
package lpm_pkg;

    typedef enum logic [2:0] {
        full_run_mode,
        sleep_level_zero,
        sleep_level_one,
        sleep_level_two,
        sleep_level_three,
        sleep_level_four
    } op_mode_e;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_SERVICE
    } ctl_state_e;

    // One enable per gated clock or analog source.
    typedef struct packed {
        logic cpuRun;
        logic mainClk;
        logic subMainClk;
        logic auxClk;
        logic dcoGen;
        logic xtalOsc;
    } clk_gate_s;

endpackage

/* rtl/low_power_mode_clock_gating.sv */
// Functional notes
// - Six modes: full run plus five software-selected sleep levels.
// - Full run mode keeps CPU, main, sub-main and auxiliary clocks running.
// - Level zero halts CPU and main clock; auxiliary and sub-main keep running.
// - Level one is level zero plus dc generator off when oscillator unused.
// - Level two halts CPU, main and sub-main; dc generator and auxiliary stay.
// - Level three leaves only the auxiliary clock; dc generator is off.
// - Level four stops every clock, the dc generator and the crystal.
// - An interrupt wakes any sleep level; handler return enters the saved level, which the handler may rewrite.
// - Crystal driver stays on its pad after reset until select bit 7 clears.
// - Test pin selects port-one JTAG functions and senses the protection fuse.
`include "lpm_defines.svh"

module low_power_mode_clock_gating (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Mode request from the CPU control bits
    input  wire logic [`SLP_CODE_W-1:0] sleepCode,
    input  wire logic                  sleepReq,
    input  wire logic                  dcoUsedInRun,
    // Interrupt handshake with the CPU core
    input  wire logic                  irqPending,
    input  wire logic                  handlerReturn,
    output logic                       wakeAck,
    // Clock and source enables
    output lpm_pkg::clk_gate_s         gateEn,
    output lpm_pkg::op_mode_e          activeMode,
    output lpm_pkg::op_mode_e          savedMode,
    // Pin control
    input  wire logic                  port2_function_select_bit7,
    input  wire logic                  testPin,
    output logic                       crystalOutDrvEn,
    output logic                       jtagPinSel,
    output logic                       fuseSenseEn
);
    import lpm_pkg::*;

    // Decodes a request code into a mode; unknown codes mean full run.
    function automatic op_mode_e codeToMode(input logic [`SLP_CODE_W-1:0] code);
        op_mode_e m;
        m = full_run_mode;
        case (code)
            `SLP_CODE_ZERO:  m = sleep_level_zero;
            `SLP_CODE_ONE:   m = sleep_level_one;
            `SLP_CODE_TWO:   m = sleep_level_two;
            `SLP_CODE_THREE: m = sleep_level_three;
            `SLP_CODE_FOUR:  m = sleep_level_four;
            default:         m = full_run_mode;
        endcase
        return m;
    endfunction

    // Enables that each mode asks for.
    function automatic clk_gate_s gatesFor(input op_mode_e m, input logic dcoUsed);
        clk_gate_s g;
        g = '{default: 1'b1};
        case (m)
            full_run_mode: begin
                g = '{default: 1'b1};
            end
            sleep_level_zero: begin
                g.cpuRun  = 1'b0;
                g.mainClk = 1'b0;
            end
            sleep_level_one: begin
                g.cpuRun  = 1'b0;
                g.mainClk = 1'b0;
                g.dcoGen  = dcoUsed;
            end
            sleep_level_two: begin
                g.cpuRun     = 1'b0;
                g.mainClk    = 1'b0;
                g.subMainClk = 1'b0;
            end
            sleep_level_three: begin
                g.cpuRun     = 1'b0;
                g.mainClk    = 1'b0;
                g.subMainClk = 1'b0;
                g.dcoGen     = 1'b0;
            end
            sleep_level_four: begin
                g = '{default: 1'b0};
            end
            default: begin
                g = '{default: 1'b1};
            end
        endcase
        return g;
    endfunction

    ctl_state_e state_ff;
    ctl_state_e nxt_state;
    op_mode_e   mode_ff;
    op_mode_e   nxt_mode;
    op_mode_e   saved_ff;
    op_mode_e   nxt_saved;
    clk_gate_s  gate_ff;
    clk_gate_s  nxt_gate;
    logic       wake_ff;
    logic       nxt_wake;
    op_mode_e   reqMode;

    assign reqMode = codeToMode(sleepCode);

    // A request and a pending interrupt in the same cycle still enter the
    // sleep level first; the level-sensitive interrupt wakes it on the next
    // edge, so the handler sees the same saved level either way.
    always_comb begin
        nxt_state = state_ff;
        nxt_mode  = mode_ff;
        nxt_saved = saved_ff;
        nxt_wake  = 1'b0;
        case (state_ff)
            ST_RUN: begin
                if (sleepReq && reqMode != full_run_mode) begin
                    nxt_state = ST_SLEEP;
                    nxt_mode  = reqMode;
                    nxt_saved = reqMode;
                end
            end
            ST_SLEEP: begin
                if (irqPending) begin
                    nxt_state = ST_SERVICE;
                    nxt_mode  = full_run_mode;
                    nxt_wake  = 1'b1;
                end
            end
            ST_SERVICE: begin
                if (handlerReturn) begin
                    if (saved_ff == full_run_mode) begin
                        nxt_state = ST_RUN;
                    end else begin
                        nxt_state = ST_SLEEP;
                    end
                    nxt_mode = saved_ff;
                end else if (sleepReq) begin
                    // The handler may rewrite the level it returns to.
                    nxt_saved = reqMode;
                end
            end
            default: begin
                nxt_state = ST_RUN;
                nxt_mode  = full_run_mode;
            end
        endcase
        // Enables come from flops only, so the external gating cells see
        // edges aligned to clk and never a decode glitch.
        nxt_gate = gatesFor(nxt_mode, dcoUsedInRun);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_RUN;
            mode_ff  <= full_run_mode;
            saved_ff <= full_run_mode;
            gate_ff  <= '{default: 1'b1};
            wake_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            mode_ff  <= nxt_mode;
            saved_ff <= nxt_saved;
            gate_ff  <= nxt_gate;
            wake_ff  <= nxt_wake;
        end
    end

    assign gateEn     = gate_ff;
    assign activeMode = mode_ff;
    assign savedMode  = saved_ff;
    assign wakeAck    = wake_ff;

    // Pin control group.
    logic xoutDrv_ff;
    logic nxt_xoutDrv;
    logic jtag_ff;
    logic nxt_jtag;

    // The driver follows the select bit; it cannot leave the pad until
    // software clears the bit, which costs current if the pad is an input.
    always_comb begin
        nxt_xoutDrv = port2_function_select_bit7;
        nxt_jtag    = testPin;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            xoutDrv_ff <= `CRYSTAL_OUTPUT_PAD_DRV_RST;
            jtag_ff    <= `JTAG_SEL_RST;
        end else begin
            xoutDrv_ff <= nxt_xoutDrv;
            jtag_ff    <= nxt_jtag;
        end
    end

    assign crystalOutDrvEn = xoutDrv_ff;
    assign jtagPinSel      = jtag_ff;
    assign fuseSenseEn     = jtag_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_MODE_LEGAL: assert property (
        activeMode inside {full_run_mode, sleep_level_zero, sleep_level_one,
                           sleep_level_two, sleep_level_three, sleep_level_four})
        else $error("Active mode left the six legal modes.");

    AST_RUN_ALL_ON: assert property (
        activeMode == full_run_mode |-> &gateEn)
        else $error("Full run mode has a clock gated.");

    AST_LVL0: assert property (
        activeMode == sleep_level_zero |-> !gateEn.cpuRun && !gateEn.mainClk
            && gateEn.auxClk && gateEn.subMainClk)
        else $error("Level zero gating wrong.");

    AST_LVL1_DCO: assert property (
        (state_ff == ST_RUN && sleepReq && sleepCode == `SLP_CODE_ONE)
            |=> !gateEn.mainClk && gateEn.subMainClk
                && gateEn.dcoGen == $past(dcoUsedInRun))
        else $error("Level one dc generator control wrong.");

    AST_LVL2: assert property (
        activeMode == sleep_level_two |-> !gateEn.subMainClk && !gateEn.mainClk
            && gateEn.dcoGen && gateEn.auxClk && !gateEn.cpuRun)
        else $error("Level two gating wrong.");

    // The crystal keeps running here because it feeds the auxiliary clock.
    AST_LVL3: assert property (
        activeMode == sleep_level_three |-> !gateEn.cpuRun && !gateEn.mainClk
            && !gateEn.subMainClk && !gateEn.dcoGen && gateEn.auxClk && gateEn.xtalOsc)
        else $error("Level three must leave only the auxiliary clock and its crystal.");

    AST_LVL4: assert property (
        activeMode == sleep_level_four |-> !(|gateEn))
        else $error("Level four left a source running.");

    AST_WAKE: assert property (
        (state_ff == ST_SLEEP && irqPending)
            |=> wakeAck && (&gateEn) ##1 !wakeAck)
        else $error("Interrupt did not wake the device in one cycle.");

    AST_RESTORE: assert property (
        (state_ff == ST_SERVICE && handlerReturn)
            |=> activeMode == $past(savedMode))
        else $error("Handler return did not restore the saved level.");

    AST_CRYSTAL_OUTPUT_PAD: assert property (
        $fell(port2_function_select_bit7) |=> !crystalOutDrvEn)
        else $error("Crystal driver stayed on after select bit cleared.");

    AST_TEST_PIN: assert property (
        testPin ##1 testPin |-> jtagPinSel && fuseSenseEn)
        else $error("Test pin did not select the test functions.");

    AST_GATE_STABLE: assert property (
        (state_ff == ST_SERVICE && !handlerReturn)
            |=> (&gateEn) && state_ff == ST_SERVICE)
        else $error("Clocks not fully running during handler.");

    AST_LVL1_GATES: assert property (
        activeMode == sleep_level_one |-> !gateEn.cpuRun && !gateEn.mainClk
            && gateEn.subMainClk && gateEn.auxClk && gateEn.xtalOsc)
        else $error("Level one gating wrong.");

    // Only level four may stop the crystal; every lighter level relies on it.
    AST_XTAL_KEPT: assert property (
        activeMode != sleep_level_four |-> gateEn.xtalOsc)
        else $error("Crystal stopped outside level four.");

    AST_ENTRY_SAVED: assert property (
        (state_ff == ST_RUN && sleepReq && reqMode != full_run_mode)
            |=> state_ff == ST_SLEEP && activeMode == $past(reqMode)
                && savedMode == $past(reqMode))
        else $error("Sleep request did not enter and save the level.");

    // A request that arrives while asleep cannot move the level; only an
    // interrupt leaves the sleep state.
    AST_SLEEP_HOLD: assert property (
        (state_ff == ST_SLEEP && !irqPending)
            |=> state_ff == ST_SLEEP && activeMode == $past(activeMode) && !wakeAck)
        else $error("Sleep level changed without an interrupt.");

    AST_NO_SPURIOUS_WAKE: assert property (
        state_ff != ST_SLEEP |=> !wakeAck)
        else $error("Wake pulse without a sleep level to leave.");

    AST_CRYSTAL_OUTPUT_PAD_BACK: assert property (
        $rose(port2_function_select_bit7) |=> crystalOutDrvEn)
        else $error("Crystal driver did not return to its pad.");

    AST_TEST_PIN_LOW: assert property (
        !testPin ##1 !testPin |-> !jtagPinSel && !fuseSenseEn)
        else $error("Test functions selected with the test pin low.");

    COV_SLEEP4: cover property (
        state_ff == ST_RUN && sleepReq && sleepCode == `SLP_CODE_FOUR);
    COV_WAKE_RETURN: cover property (
        state_ff == ST_SLEEP && irqPending ##[1:20] handlerReturn);
    COV_LVL1_DCO_OFF: cover property (
        activeMode == sleep_level_one && !gateEn.dcoGen);
    COV_HANDLER_RELEVEL: cover property (
        state_ff == ST_SERVICE && sleepReq && reqMode != full_run_mode);

endmodule // low_power_mode_clock_gating

/* tb/cpu_core_model.sv */
`include "lpm_defines.svh"

module cpu_core_model (
    // Clock
    input  wire logic                  clk,
    // Requests toward the controller
    output logic [`SLP_CODE_W-1:0]     sleepCode,
    output logic                       sleepReq,
    output logic                       handlerReturn,
    output logic                       selBit7
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sleepCode     = `SLP_CODE_RUN;
        sleepReq      = 1'h0;
        handlerReturn = 1'h0;
        selBit7       = `CRYSTAL_OUTPUT_PAD_DRV_RST;
    end

    // A released code shows its inverse so a stale value is never mistaken for a request.
    task automatic requestMode(input logic [`SLP_CODE_W-1:0] code);
        @(posedge clk);
        #1;
        sleepCode = code;
        sleepReq  = 1'h1;
        @(posedge clk);
        #1;
        sleepReq  = 1'h0;
        sleepCode = ~code;
    endtask

    // The handler may run briefly or for a long time before it returns.
    task automatic returnFromHandler(input int waitCycles);
        repeat (waitCycles) @(posedge clk);
        @(posedge clk);
        #1;
        handlerReturn = 1'h1;
        @(posedge clk);
        #1;
        handlerReturn = 1'h0;
    endtask

    task automatic setSelect(input logic value);
        @(posedge clk);
        #1;
        selBit7 = value;
    endtask
endmodule // cpu_core_model

/* tb/test_low_power_mode_clock_gating.sv */
`include "lpm_defines.svh"

module test_low_power_mode_clock_gating;
    import lpm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk          = 1'h0;
    logic                   sys_rst      = 1'h1;
    logic                   dcoUsedInRun = 1'h0;
    logic                   irqPending   = 1'h0;
    logic                   testPin      = 1'h0;
    logic [`SLP_CODE_W-1:0] sleepCode;
    logic                   sleepReq;
    logic                   handlerReturn;
    logic                   selBit7;
    logic                   wakeAck;
    logic                   crystalOutDrvEn;
    logic                   jtagPinSel;
    logic                   fuseSenseEn;
    clk_gate_s              gateEn;
    op_mode_e               activeMode;
    op_mode_e               savedMode;
    int                     errTotal = 0;
    int                     testsRun = 0;
    int                     cycles   = 0;
    logic [2:0]             codeTab [6] = '{`SLP_CODE_RUN, `SLP_CODE_ZERO, `SLP_CODE_ONE,
                                            `SLP_CODE_TWO, `SLP_CODE_THREE, `SLP_CODE_FOUR};

    always #10 clk = ~clk;

    low_power_mode_clock_gating u_low_power_mode_clock_gating (
        .clk                        (clk),
        .sys_rst                    (sys_rst),
        .sleepCode                  (sleepCode),
        .sleepReq                   (sleepReq),
        .dcoUsedInRun               (dcoUsedInRun),
        .irqPending                 (irqPending),
        .handlerReturn              (handlerReturn),
        .wakeAck                    (wakeAck),
        .gateEn                     (gateEn),
        .activeMode                 (activeMode),
        .savedMode                  (savedMode),
        .port2_function_select_bit7 (selBit7),
        .testPin                    (testPin),
        .crystalOutDrvEn            (crystalOutDrvEn),
        .jtagPinSel                 (jtagPinSel),
        .fuseSenseEn                (fuseSenseEn)
    );

    cpu_core_model u_cpu_core_model (
        .clk           (clk),
        .sleepCode     (sleepCode),
        .sleepReq      (sleepReq),
        .handlerReturn (handlerReturn),
        .selBit7       (selBit7)
    );

    function automatic clk_gate_s expGates(input op_mode_e m, input logic tunable_rc_oscillator);
        case (m)
            sleep_level_zero:  return 6'h0F;
            sleep_level_one:   return {4'h3, tunable_rc_oscillator, 1'h1};
            sleep_level_two:   return 6'h07;
            sleep_level_three: return 6'h05;
            sleep_level_four:  return 6'h00;
            default:           return 6'h3F;
        endcase
    endfunction

    task automatic checkBit(input string what, input logic exp, input logic got);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkGates(input string what, input clk_gate_s exp, input clk_gate_s got);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkMode(input string what, input op_mode_e exp, input op_mode_e got);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic printVerdict();
        $display("Comparisons %0d, mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic pulseIrq();
        @(posedge clk);
        #1;
        irqPending = 1'h1;
        @(posedge clk);
        #1;
        irqPending = 1'h0;
    endtask

    task automatic wakeUp();
        pulseIrq();
        checkBit("wakeAck", 1'h1, wakeAck);
        checkGates("wakeGates", 6'h3F, gateEn);
        @(posedge clk);
        #1;
        checkBit("wakeAckEnd", 1'h0, wakeAck);
        checkMode("handlerMode", full_run_mode, activeMode);
    endtask

    task automatic testReset();
        checkGates("rstGates", 6'h3F, gateEn);
        checkMode("rstMode", full_run_mode, activeMode);
        checkMode("rstSaved", full_run_mode, savedMode);
        checkBit("rstWake", 1'h0, wakeAck);
        checkBit("rstXtalDrv", `CRYSTAL_OUTPUT_PAD_DRV_RST, crystalOutDrvEn);
        checkBit("rstJtag", `JTAG_SEL_RST, jtagPinSel);
        checkBit("rstFuse", `JTAG_SEL_RST, fuseSenseEn);
    endtask

    task automatic testRunRefuse();
        u_cpu_core_model.requestMode(`SLP_CODE_RUN);
        checkMode("runReq", full_run_mode, activeMode);
        pulseIrq();
        checkBit("runIrq", 1'h0, wakeAck);
        checkGates("runGates", 6'h3F, gateEn);
    endtask

    task automatic testLevels();
        op_mode_e m;
        for (int i = 1; i < 6; i++) begin
            m = op_mode_e'(i);
            u_cpu_core_model.requestMode(codeTab[i]);
            checkMode("sleepMode", m, activeMode);
            checkMode("savedMode", m, savedMode);
            checkGates("sleepGates", expGates(m, 1'h0), gateEn);
            u_cpu_core_model.requestMode(codeTab[i % 5 + 1]);
            checkMode("asleepReq", m, activeMode);
            wakeUp();
            u_cpu_core_model.returnFromHandler(i * 2);
            checkMode("restored", m, activeMode);
            checkGates("restGates", expGates(m, 1'h0), gateEn);
            wakeUp();
            u_cpu_core_model.requestMode(`SLP_CODE_RUN);
            u_cpu_core_model.returnFromHandler(0);
            checkMode("exitMode", full_run_mode, activeMode);
            checkMode("exitSaved", full_run_mode, savedMode);
        end
    endtask

    task automatic testLevelOne();
        dcoUsedInRun = 1'h1;
        u_cpu_core_model.requestMode(`SLP_CODE_ONE);
        checkGates("dcoKept", expGates(sleep_level_one, 1'h1), gateEn);
        wakeUp();
        u_cpu_core_model.requestMode(`SLP_CODE_ZERO);
        checkMode("relevelSaved", sleep_level_zero, savedMode);
        u_cpu_core_model.returnFromHandler(1);
        checkMode("relevelMode", sleep_level_zero, activeMode);
        checkGates("relevelGates", expGates(sleep_level_zero, 1'h1), gateEn);
        wakeUp();
        u_cpu_core_model.requestMode(`SLP_CODE_RUN);
        u_cpu_core_model.returnFromHandler(1);
        checkMode("relevelExit", full_run_mode, activeMode);
        dcoUsedInRun = 1'h0;
    endtask

    task automatic testMidReset();
        u_cpu_core_model.requestMode(`SLP_CODE_THREE);
        checkMode("preRstMode", sleep_level_three, activeMode);
        sys_rst = 1'h1;
        #1;
        testReset();
        @(posedge clk);
        #1;
        sys_rst = 1'h0;
        testReset();
        u_cpu_core_model.requestMode(`SLP_CODE_ZERO);
        checkMode("postRstMode", sleep_level_zero, activeMode);
        wakeUp();
        u_cpu_core_model.requestMode(`SLP_CODE_RUN);
        u_cpu_core_model.returnFromHandler(0);
        checkMode("postRstExit", full_run_mode, activeMode);
    endtask

    task automatic testPins();
        testPin = 1'h1;
        u_cpu_core_model.setSelect(1'h0);
        @(posedge clk);
        #1;
        checkBit("jtagSel", 1'h1, jtagPinSel);
        checkBit("fuseSense", 1'h1, fuseSenseEn);
        checkBit("xtalDrvOff", 1'h0, crystalOutDrvEn);
        testPin = 1'h0;
        u_cpu_core_model.setSelect(1'h1);
        @(posedge clk);
        #1;
        checkBit("jtagOff", 1'h0, jtagPinSel);
        checkBit("fuseOff", 1'h0, fuseSenseEn);
        checkBit("xtalDrvOn", 1'h1, crystalOutDrvEn);
        @(posedge clk);
        #1;
        checkBit("xtalDrvHold", 1'h1, crystalOutDrvEn);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errTotal++;
            printVerdict();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'h0;
        testReset();
        testRunRefuse();
        testLevels();
        testLevelOne();
        testMidReset();
        testPins();
        printVerdict();
    end
endmodule // test_low_power_mode_clock_gating
